// *** src_pkg.sv ***
package src_pkg;
   // Clock and timing figures
   localparam int CLK_PERIOD_NS = 4;
   localparam int FILT_MIN_NS = 1500;
   localparam int FILT_MAX_NS = 5000;
   // Least filter time rounds up to whole cycles
   localparam int FILT_CYC = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 9;
   // Longest input blanking time rounds down
   localparam int BLANK_NS = 1000;
   localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
   localparam int BLANK_W = 8;
   // Release stretch in serial clock periods
   localparam int DLY_SCLK = 128;
   localparam int DLY_W = 8;

   // Monitored fault inputs
   localparam int NFLT = 6;
   localparam int FI_V5 = 0;
   localparam int FI_V33 = 1;
   localparam int FI_CORE = 2;
   localparam int FI_BATT = 3;
   localparam int FI_TSD = 4;
   localparam int FI_TSDC = 5;
   // Synchroniser lanes: faults, reset line, serial clock
   localparam int SYNC_W = 8;
   localparam int SY_RST = 6;
   localparam int SY_SCLK = 7;
   localparam logic [SYNC_W-1:0] SYNC_RST = 8'h40;

   // Fault flags of the status report word
   localparam int NFLAG = 7;
   localparam int FL_EXT = 0;
   localparam int FL_FLT = 1;
   localparam int STS_LINE = 8;
   localparam int STS_THERM = 9;

   // Register byte addresses
   localparam int AW = 4;
   localparam logic [AW-1:0] ADDR_STATUS = 4'h0;
   localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'h8;
   localparam logic [AW-1:0] ADDR_CTRL = 4'hC;
   localparam int CTRL_SWRST = 0;
   localparam int NIRQ = 3;
   localparam int IRQ_ASSERT = 0;
   localparam int IRQ_RELEASE = 1;
   localparam int IRQ_EXT = 2;

   // Bridge leg drive codes
   localparam logic [1:0] LEG_LS_ON = 2'h0;
   localparam logic [1:0] LEG_HS_ON = 2'h1;
   localparam logic [1:0] LEG_OFF = 2'h2;
   localparam logic [1:0] LEG_FREE = 2'h3;

   typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY, ST_BLANK} src_state_t;
endpackage

// *** src_mon_if.sv ***
`timescale 1ns/100ps
interface src_mon_if;
   import src_pkg::*;
   logic [NFLT-1:0] fault_s;
   logic rst_n_s;
   logic sclk_s;
   logic [NFLT-1:0] fault_f;
   modport sync_mp (output fault_s, output rst_n_s, output sclk_s);
   modport filt_mp (input fault_s, output fault_f);
   modport core_mp (input fault_s, input rst_n_s, input sclk_s, input fault_f);
endinterface

// *** src_sync.sv ***
`timescale 1ns/100ps
module src_sync (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [src_pkg::SYNC_W-1:0] async_i,
   src_mon_if.sync_mp mon
);
   import src_pkg::*;
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } src_sync_t;
   src_sync_t r;
   src_sync_t r_nxt;

   // Two stages; only the second one is ever looked at
   always_comb begin
      r_nxt = r;
      r_nxt.s1 = async_i;
      r_nxt.s2 = r.s1;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         r <= '{s1: SYNC_RST, s2: SYNC_RST};
      end else if (ce_i) begin
         r <= r_nxt;
      end
   end

   assign mon.fault_s = r.s2[NFLT-1:0];
   assign mon.rst_n_s = r.s2[SY_RST];
   assign mon.sclk_s = r.s2[SY_SCLK];
endmodule // src_sync

// *** src_filter.sv ***
`timescale 1ns/100ps
module src_filter (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   src_mon_if.filt_mp mon
);
   import src_pkg::*;
   typedef struct packed {
      logic [NFLT-1:0][FILT_W-1:0] cnt;
      logic [NFLT-1:0] filt;
   } src_filt_t;
   src_filt_t r;
   src_filt_t r_nxt;

   // Persistence counters; a dropout restarts the count
   always_comb begin
      r_nxt = r;
      for (int i = 0; i < NFLT; i++) begin
         if (!mon.fault_s[i]) begin
            r_nxt.cnt[i] = '0;
            r_nxt.filt[i] = 1'b0;
         end else if (r.cnt[i] == FILT_W'(FILT_CYC - 1)) begin
            r_nxt.filt[i] = 1'b1;
         end else begin
            r_nxt.cnt[i] = r.cnt[i] + FILT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= r_nxt;
      end
   end

   assign mon.fault_f = r.filt;

   property p_filt_min;
      @(posedge clk_i) disable iff (srst_i)
      $rose(r.filt[FI_V5]) |-> $past(r.cnt[FI_V5]) == FILT_W'(FILT_CYC - 1);
   endproperty
   a_filt_min: assert property (p_filt_min) else $error("fault passed filter early");
endmodule // src_filter

// *** src_top.sv ***
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module src_top (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [src_pkg::NFLT-1:0] fault_i,
   input wire logic sclk_i,
   input wire logic rst_n_i,
   output logic rst_n_o,
   output logic rst_n_oe_o,
   input wire logic [src_pkg::AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   output logic [src_pkg::NFLAG-1:0] status_report_word_o,
   output logic [1:0] dc_bridge_leg_a_o,
   output logic [1:0] dc_bridge_leg_b_o,
   output logic step_motor_outputs_off_o,
   output logic miso_hiz_o,
   output logic reg5_en_o,
   output logic reg33_en_o,
   output logic core_supply_en_o,
   output logic circuit_disable_o,
   output logic data_reg_reset_o
);
   import src_pkg::*;

   typedef struct packed {
      src_state_t st;
      logic [DLY_W-1:0] dly;
      logic [BLANK_W-1:0] blk;
      logic sclk_d;
      logic [NFLAG-1:0] flags;
      logic [NIRQ-1:0] ist;
      logic [NIRQ-1:0] imask;
      logic swreq;
      logic [31:0] rdata;
      logic drv;
      logic oe;
      logic irq;
      logic [1:0] leg;
      logic step_off;
      logic miso_hiz;
      logic en5;
      logic en33;
      logic encore;
      logic cdis;
      logic drst;
   } src_top_t;

   // Power-on: line held low, a full release count follows
   localparam src_top_t TOP_RST = '{st: ST_HOLD, oe: 1'b1, step_off: 1'b1, miso_hiz: 1'b1,
      en5: 1'b1, en33: 1'b1, encore: 1'b1, drst: 1'b1, leg: LEG_LS_ON, default: '0};

   src_top_t r;
   src_top_t r_nxt;

   src_mon_if mon ();

   // Every pin-side input goes through the synchroniser
   src_sync u_sync (
      .clk_i (clk_i),
      .srst_i (srst_i),
      .ce_i (ce_i),
      .async_i ({sclk_i, rst_n_i, fault_i}),
      .mon (mon.sync_mp)
   );

   src_filter u_filter (
      .clk_i (clk_i),
      .srst_i (srst_i),
      .ce_i (ce_i),
      .mon (mon.filt_mp)
   );

   // Cause flags for one reset start
   function automatic logic [NFLAG-1:0] cause(input logic [NFLT-1:0] flt, input logic external_reset_flag);
      cause = {flt, external_reset_flag};
   endfunction

   // Register read mux
   function automatic logic [31:0] rd_mux(input logic [AW-1:0] a, input src_top_t s);
      rd_mux = '0;
      case (a)
         ADDR_STATUS: begin
            rd_mux[NFLAG-1:0] = s.flags;
            rd_mux[STS_LINE] = s.oe;
            rd_mux[STS_THERM] = s.cdis;
         end
         ADDR_IRQ_STAT: rd_mux[NIRQ-1:0] = s.ist;
         ADDR_IRQ_MASK: rd_mux[NIRQ-1:0] = s.imask;
         ADDR_CTRL: rd_mux[CTRL_SWRST] = s.swreq;
         default: rd_mux = '0;
      endcase
   endfunction

   logic sclk_rise;
   logic any_flt;
   logic therm;
   logic ext_det;
   logic int_req;
   logic [NIRQ-1:0] ev;

   // Event decode from synchronised inputs
   always_comb begin
      sclk_rise = mon.sclk_s && !r.sclk_d;
      any_flt = |mon.fault_f;
      therm = mon.fault_f[FI_TSD] || mon.fault_f[FI_TSDC];
      int_req = any_flt || r.swreq;
      // Line low while we are not pulling and not blanked
      ext_det = (r.st == ST_RUN) && !mon.rst_n_s;
   end

   // Supervisor sequence and register file
   always_comb begin
      r_nxt = r;
      ev = '0;
      r_nxt.sclk_d = mon.sclk_s;
      case (r.st)
         ST_RUN: begin
            if (ext_det) begin
               // Outside reset: old causes wiped, external cause recorded
               r_nxt.st = ST_HOLD;
               r_nxt.flags = cause(mon.fault_f, 1'b1);
               ev[IRQ_EXT] = 1'b1;
               ev[IRQ_ASSERT] = 1'b1;
            end else if (int_req) begin
               r_nxt.st = ST_HOLD;
               r_nxt.flags = r.flags | cause(mon.fault_f, 1'b0);
               ev[IRQ_ASSERT] = 1'b1;
            end
         end
         ST_HOLD: begin
            // Thermal faults sit here too; cooling starts a full count
            if (!int_req) begin
               r_nxt.st = ST_DELAY;
               r_nxt.dly = '0;
            end
         end
         ST_DELAY: begin
            if (any_flt) begin
               r_nxt.st = ST_HOLD;
               r_nxt.dly = '0;
            end else if (sclk_rise) begin
               if (r.dly == DLY_W'(DLY_SCLK - 1)) begin
                  r_nxt.st = ST_BLANK;
                  r_nxt.blk = '0;
                  ev[IRQ_RELEASE] = 1'b1;
               end else begin
                  r_nxt.dly = r.dly + DLY_W'(1);
               end
            end
         end
         ST_BLANK: begin
            // Slow pull-up: the line input is not trusted yet
            if (any_flt) begin
               r_nxt.st = ST_HOLD;
               r_nxt.flags = r.flags | cause(mon.fault_f, 1'b0);
               ev[IRQ_ASSERT] = 1'b1;
            end else if (r.blk == BLANK_W'(BLANK_CYC - 1)) begin
               r_nxt.st = ST_RUN;
            end else begin
               r_nxt.blk = r.blk + BLANK_W'(1);
            end
         end
         default: begin
            r_nxt.st = ST_HOLD;
         end
      endcase

      // Open drain: the pad only ever pulls low
      r_nxt.drv = 1'b0;
      r_nxt.oe = (r_nxt.st == ST_HOLD) || (r_nxt.st == ST_DELAY);
      r_nxt.drst = r_nxt.oe;
      r_nxt.cdis = therm;

      // Shutdown schedule by condition
      if (mon.fault_f[FI_TSDC]) begin
         r_nxt.leg = LEG_OFF;
         r_nxt.step_off = 1'b1;
         r_nxt.en5 = 1'b0;
         r_nxt.en33 = 1'b0;
         r_nxt.encore = 1'b0;
         r_nxt.miso_hiz = 1'b0;
      end else if (mon.fault_f[FI_TSD]) begin
         r_nxt.leg = LEG_OFF;
         r_nxt.step_off = 1'b1;
         r_nxt.en5 = 1'b0;
         r_nxt.en33 = 1'b0;
         r_nxt.encore = 1'b1;
         r_nxt.miso_hiz = 1'b0;
      end else begin
         // Regulators back on as soon as the die has cooled
         r_nxt.en5 = 1'b1;
         r_nxt.en33 = 1'b1;
         r_nxt.encore = 1'b1;
         r_nxt.leg = r_nxt.oe ? LEG_LS_ON : LEG_FREE;
         r_nxt.step_off = r_nxt.oe;
         r_nxt.miso_hiz = r_nxt.oe;
      end

      // Register writes; set beats a clear in the same cycle
      if (wr_i && addr_i == ADDR_IRQ_STAT) begin
         r_nxt.ist = r.ist & ~wdata_i[NIRQ-1:0];
      end
      r_nxt.ist = r_nxt.ist | ev;
      if (wr_i && addr_i == ADDR_IRQ_MASK) begin
         r_nxt.imask = wdata_i[NIRQ-1:0];
      end
      if (wr_i && addr_i == ADDR_CTRL) begin
         r_nxt.swreq = wdata_i[CTRL_SWRST];
      end
      // Software reset request falls back to 0 while reset is out; IRQ status and mask keep their values
      if (r_nxt.oe) begin
         r_nxt.swreq = 1'b0;
      end
      r_nxt.rdata = rd_i ? rd_mux(addr_i, r) : '0;
      r_nxt.irq = |(r_nxt.ist & r_nxt.imask);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         r <= TOP_RST;
      end else if (ce_i) begin
         r <= r_nxt;
      end
   end

   // All outputs straight from the state register
   assign rst_n_o = r.drv;
   assign rst_n_oe_o = r.oe;
   assign rdata_o = r.rdata;
   assign irq_o = r.irq;
   assign status_report_word_o = r.flags;
   assign dc_bridge_leg_a_o = r.leg;
   assign dc_bridge_leg_b_o = r.leg;
   assign step_motor_outputs_off_o = r.step_off;
   assign miso_hiz_o = r.miso_hiz;
   assign reg5_en_o = r.en5;
   assign reg33_en_o = r.en33;
   assign core_supply_en_o = r.encore;
   assign circuit_disable_o = r.cdis;
   assign data_reg_reset_o = r.drst;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   property p_fault_holds;
      ce_i && any_flt |=> rst_n_oe_o;
   endproperty
   a_fault_holds: assert property (p_fault_holds) else $error("fault did not hold reset");

   property p_ext_answer;
      ce_i && ext_det |=> rst_n_oe_o && r.flags[FL_EXT];
   endproperty
   a_ext_answer: assert property (p_ext_answer) else $error("external reset not answered");

   property p_release_count;
      $fell(rst_n_oe_o) |-> $past(r.dly) == DLY_W'(DLY_SCLK - 1) && $past(sclk_rise);
   endproperty
   a_release_count: assert property (p_release_count) else $error("release before count");

   property p_retrigger;
      ce_i && r.st == ST_DELAY && any_flt |=> r.st == ST_HOLD && r.dly == '0;
   endproperty
   a_retrigger: assert property (p_retrigger) else $error("count not restarted");

   property p_blank;
      ce_i && r.st == ST_BLANK && !any_flt && r.blk != BLANK_W'(BLANK_CYC - 1)
         |=> !rst_n_oe_o;
   endproperty
   a_blank: assert property (p_blank) else $error("line input used while blanked");

   property p_ext_flag_cause;
      $rose(r.flags[FL_EXT]) |-> $past(ext_det);
   endproperty
   a_ext_flag_cause: assert property (p_ext_flag_cause) else $error("external flag set wrongly");

   property p_flags_kept;
      ce_i && !ext_det |=> (r.flags & $past(r.flags)) == $past(r.flags);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags lost without external");

   property p_reset_outputs;
      rst_n_oe_o && !circuit_disable_o |-> miso_hiz_o && step_motor_outputs_off_o
         && dc_bridge_leg_a_o == LEG_LS_ON;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("reset drive state wrong");

   property p_thermal;
      ce_i && mon.fault_f[FI_TSD] |=> circuit_disable_o && !reg5_en_o && !reg33_en_o
         && dc_bridge_leg_b_o == LEG_OFF;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal schedule wrong");
endmodule // src_top

// *** src_cpu_model.sv ***
`timescale 1ns/100ps
// Host processor sharing the wired-OR reset line
module src_cpu_model (
   input wire logic clk_i,
   input wire logic pull_req_i,
   input wire logic dev_oe_i,
   input wire logic dev_o_i,
   output logic line_o
);
   logic cpu_oe_r;
   // Processor port is registered, so its pull lands one edge late
   always_ff @(posedge clk_i) begin
      cpu_oe_r <= pull_req_i;
   end
   // Open drain: either party pulls low, the pull-up wins otherwise
   assign line_o = ~(cpu_oe_r | (dev_oe_i & ~dev_o_i));
endmodule // src_cpu_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import src_pkg::*;
   localparam logic [12:0] DEF = {2'b10, LEG_LS_ON, LEG_LS_ON, 7'h7D};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [NFLT-1:0] fault_i = '0;
   logic sclk_i = 1'b0;
   logic cpu_pull = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [AW-1:0] addr_i = '0;
   logic [31:0] wdata_i = '0;
   logic [31:0] rdata_o;
   logic [31:0] d;
   logic rst_n_i, rst_n_o, rst_n_oe_o, irq_o, step_o, miso_o, r5_o, r33_o, core_o, cdis_o, drr_o;
   logic [NFLAG-1:0] flags_o;
   logic [1:0] leg_a_o, leg_b_o;
   int err_count = 0;
   int compares = 0;
   int n;

   always #2 clk_i = ~clk_i;
   // Serial clock of 8 cycles, well under the clk/2 counting limit
   always begin
      repeat (4) @(posedge clk_i);
      sclk_i <= ~sclk_i;
   end

   src_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .fault_i(fault_i),
      .sclk_i(sclk_i), .rst_n_i(rst_n_i), .rst_n_o(rst_n_o), .rst_n_oe_o(rst_n_oe_o),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .irq_o(irq_o), .status_report_word_o(flags_o), .dc_bridge_leg_a_o(leg_a_o),
      .dc_bridge_leg_b_o(leg_b_o), .step_motor_outputs_off_o(step_o), .miso_hiz_o(miso_o),
      .reg5_en_o(r5_o), .reg33_en_o(r33_o), .core_supply_en_o(core_o),
      .circuit_disable_o(cdis_o), .data_reg_reset_o(drr_o));
   src_cpu_model cpu (.clk_i(clk_i), .pull_req_i(cpu_pull), .dev_oe_i(rst_n_oe_o),
      .dev_o_i(rst_n_o), .line_o(rst_n_i));

   function automatic logic [12:0] snap();
      return {rst_n_oe_o, rst_n_o, leg_a_o, leg_b_o, step_o, miso_o, r5_o, r33_o, core_o,
         cdis_o, drr_o};
   endfunction

   task automatic end_sim();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   // Bounded wait for the line drive; running out ends the run
   task automatic wait_oe(input logic v, input int lim, output int c);
      c = 0;
      while (rst_n_oe_o !== v) begin
         @(posedge clk_i);
         #1;
         c++;
         if (c > lim) begin
            err_count++;
            end_sim();
         end
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic flt(input int i, input int c);
      @(posedge clk_i);
      fault_i[i] <= 1'b1;
      cyc(c);
      fault_i[i] <= 1'b0;
   endtask

   // Power-on defaults, then the first release count
   task automatic t_reset();
      cyc(11);
      #1;
      chk(snap(), DEF);
      chk(flags_o, 7'h00);
      @(posedge clk_i);
      srst_i <= 1'b0;
      wait_oe(1'b0, 1300, n);
      chk(n >= 1010 && n <= 1045, 1);
      wr(ADDR_IRQ_MASK, 32'h0);
      cyc(260);
   endtask

   // Short glitch ignored, long fault held, recurrence restarts count
   task automatic t_fault();
      flt(FI_V5, 300);
      cyc(5);
      #1;
      chk(rst_n_oe_o, 1'b0);
      flt(FI_V5, 400);
      #1;
      chk(rst_n_oe_o, 1'b1);
      chk(flags_o, 7'h02);
      chk(snap(), DEF);
      cyc(400);
      flt(FI_BATT, 400);
      wait_oe(1'b0, 1300, n);
      chk(n >= 1010 && n <= 1045, 1);
      chk(flags_o, 7'h02);
      cyc(260);
   endtask

   // Processor-started reset, interrupt path, blanking afterwards
   task automatic t_ext();
      wr(ADDR_IRQ_STAT, 32'h7);
      wr(ADDR_IRQ_MASK, 32'h4);
      #1;
      chk(irq_o, 1'b0);
      @(posedge clk_i);
      cpu_pull <= 1'b1;
      wait_oe(1'b1, 8, n);
      cyc(10);
      cpu_pull <= 1'b0;
      #1;
      chk(flags_o, 7'h01);
      chk(irq_o, 1'b1);
      rd(ADDR_IRQ_STAT, d);
      chk(d, 32'h5);
      wr(ADDR_IRQ_STAT, 32'h4);
      cyc(2);
      #1;
      chk(irq_o, 1'b0);
      rd(4'h2, d);
      chk(d, 32'h0);
      wait_oe(1'b0, 1300, n);
      rd(ADDR_STATUS, d);
      chk(d, 32'h1);
      cyc(15);
      cpu_pull <= 1'b1;
      cyc(10);
      cpu_pull <= 1'b0;
      cyc(5);
      #1;
      chk(rst_n_oe_o, 1'b0);
      cyc(260);
   endtask

   // Software reset is internal: flags survive, no external mark
   // Clock enable low freezes the release count, so release slips
   task automatic t_sw();
      wr(ADDR_CTRL, 32'h1);
      wait_oe(1'b1, 6, n);
      chk(flags_o, 7'h01);
      @(posedge clk_i);
      ce_i <= 1'b0;
      cyc(200);
      #1;
      chk(rst_n_oe_o, 1'b1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      wait_oe(1'b0, 1300, n);
      chk(n >= 1000 && n <= 1045, 1);
      cyc(260);
   endtask

   // Over-temperature schedule and recovery
   task automatic t_therm();
      @(posedge clk_i);
      fault_i[FI_TSD] <= 1'b1;
      cyc(400);
      #1;
      chk({leg_a_o, leg_b_o, step_o, r5_o, r33_o, core_o, cdis_o, rst_n_oe_o},
         {LEG_OFF, LEG_OFF, 6'h27});
      @(posedge clk_i);
      fault_i[FI_TSDC] <= 1'b1;
      cyc(400);
      #1;
      chk({r5_o, r33_o, core_o}, 3'h0);
      @(posedge clk_i);
      fault_i <= '0;
      cyc(10);
      #1;
      chk({r5_o, r33_o, core_o, cdis_o, rst_n_oe_o}, 5'h1D);
      wait_oe(1'b0, 1300, n);
      chk(n >= 1000 && n <= 1045, 1);
      chk(flags_o[5], 1'b1);
   endtask

   initial begin
      t_reset();
      t_fault();
      t_ext();
      t_sw();
      t_therm();
      end_sim();
   end
endmodule // tb_top
